// >>> hw/phac_pci_ctrl.sv
// Functional notes
// - target asserts stop to end a transaction; master must then terminate.
// - exclusive lock honoured only for processor-started sequences, may span many.
// - locked cycles from PCI initiators get no exclusive treatment.
// - non-exclusive transactions keep flowing while lock is asserted.
// - a master gets the bus through its own active-low grant line.
// - on bridge hold, drain write and posting buffers, take host bus, then grant.
// - bridge ownership is given by asserting the hold acknowledge.
// - hold handshake also supports passive release.
// - one parity bit covers address/data and command/byte-enable lines.
// - system error asserted when a reportable error is detected.
// - clock-run pulled low to start or keep the PCI clock.
// - clock-run is open-drain, only pulled low or released, and sampled.
// - clock-run released when reset ends.
// - reset input acts asynchronously.
// - all PCI outputs float while reset is asserted.
// - memory cycles are claimed with device-select at medium decode timing.
`timescale 1ns/100ps
`default_nettype none
module phac_pci_ctrl
(
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic [phac_pkg::NUM_MASTERS-1:0] REQ_N_I,
   output logic [phac_pkg::NUM_MASTERS-1:0] GNT_N_O,
   output logic GNT_OE_O,
   input wire logic BRIDGE_HOLD_REQUEST_N_I,
   output logic BRIDGE_HOLD_ACK_N_O,
   output logic BRIDGE_HOLD_ACK_OE_O,
   input wire logic WR_BUF_EMPTY_I,
   input wire logic POST_BUF_EMPTY_I,
   output logic HOST_BUS_REQ_O,
   input wire logic HOST_BUS_GNT_I,
   input wire logic CPU_LOCK_I,
   output logic BUS_LOCK_N_O,
   output logic BUS_LOCK_OE_O,
   input wire logic FRAME_N_I,
   input wire logic IRDY_N_I,
   input wire logic [phac_pkg::AD_W-1:0] AD_I,
   input wire logic [phac_pkg::CBE_W-1:0] CBE_N_I,
   input wire logic PAR_I,
   input wire logic [phac_pkg::AD_W-1:0] RD_DATA_I,
   input wire logic TGT_READY_I,
   input wire logic TGT_RETRY_I,
   output logic [phac_pkg::AD_W-1:0] AD_O,
   output logic AD_OE_O,
   output logic PAR_O,
   output logic PAR_OE_O,
   output logic DEVSEL_N_O,
   output logic TRDY_N_O,
   output logic STOP_N_O,
   output logic TGT_OE_O,
   input wire logic ERR_EVENT_I,
   output logic SERR_N_O,
   output logic SERR_OE_O,
   input wire logic CLK_NEEDED_I,
   input wire logic CLKRUN_N_I,
   output logic CLKRUN_N_O,
   output logic CLKRUN_OE_O
);
   import phac_pkg::*;

   // ----------------------------------------------------------------
   // input capture and arbitration
   // ----------------------------------------------------------------
   logic [SYNC_W-1:0] sync_q;
   logic [NUM_MASTERS-1:0] req_m;
   logic hold_req;
   logic cr_high;
   logic bus_idle;
   logic frame_q;
   logic addr_phase;
   logic mem_cmd;
   logic addr_hit;
   logic [ARB_W-1:0] gnt_n;
   logic [ARB_W-1:0] arb_req;
   logic hold_slot_req;
   phac_hold_t hstate;

   phac_sync u_sync
   (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .d_i({CLKRUN_N_I, BRIDGE_HOLD_REQUEST_N_I, REQ_N_I}),
      .q_o(sync_q)
   );

   assign req_m = ~sync_q[NUM_MASTERS-1:0];
   assign hold_req = ~sync_q[NUM_MASTERS];
   assign cr_high = sync_q[NUM_MASTERS+1];
   // bus lines are synchronous to this clock, so no extra stages here
   assign bus_idle = FRAME_N_I & IRDY_N_I;
   assign addr_phase = frame_q & ~FRAME_N_I;
   assign mem_cmd = (CBE_N_I == CMD_MEM_RD) || (CBE_N_I == CMD_MEM_WR) ||
                    (CBE_N_I == CMD_MEM_RD_MULT) ||
                    (CBE_N_I == CMD_MEM_RD_LINE) ||
                    (CBE_N_I == CMD_MEM_WR_INV);
   // lock from a PCI initiator is not looked at: such cycles decode
   // like any other and get no exclusive treatment
   assign addr_hit = addr_phase & mem_cmd & (AD_I < DRAM_TOP);
   assign hold_slot_req = hold_req &
                          (((hstate == H_HOST) & HOST_BUS_GNT_I) |
                           (hstate == H_ACK));
   assign arb_req = {hold_slot_req, req_m};

   phac_arb u_arb
   (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .req_i(arb_req),
      .bus_idle_i(bus_idle),
      .gnt_n_o(gnt_n)
   );

   assign GNT_N_O = gnt_n[NUM_MASTERS-1:0];

   // ----------------------------------------------------------------
   // bridge hold handshake
   // ----------------------------------------------------------------
   phac_hold_t next_hstate;
   logic next_ack_n;
   logic next_host_req;
   logic pci_on;

   always_comb
   begin
      next_hstate = hstate;
      case (hstate)
         H_IDLE:
            if (hold_req)
               next_hstate = H_DRAIN;
         H_DRAIN:
            if (!hold_req)
               next_hstate = H_IDLE;
            else if (WR_BUF_EMPTY_I && POST_BUF_EMPTY_I)
               next_hstate = H_HOST;
         H_HOST:
            if (!hold_req)
               next_hstate = H_IDLE;
            else if (!gnt_n[HOLD_SLOT] && HOST_BUS_GNT_I)
               next_hstate = H_ACK;
         H_ACK:
            if (!hold_req)
               next_hstate = H_IDLE;
            else if (bus_idle && (req_m != '0))
               next_hstate = H_PASSIVE;
         H_PASSIVE:
            // others may have posted writes meanwhile, so drain again
            if (!hold_req)
               next_hstate = H_IDLE;
            else if (bus_idle && (req_m == '0) && (&gnt_n))
               next_hstate = H_DRAIN;
         default:
            next_hstate = H_IDLE;
      endcase
      next_ack_n = (next_hstate != H_ACK);
      next_host_req = (next_hstate == H_HOST) || (next_hstate == H_ACK) ||
                      (next_hstate == H_PASSIVE);
   end

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         hstate <= H_IDLE;
         BRIDGE_HOLD_ACK_N_O <= 1'b1;
         HOST_BUS_REQ_O <= 1'b0;
         pci_on <= 1'b0;
      end
      else
      begin
         hstate <= next_hstate;
         BRIDGE_HOLD_ACK_N_O <= next_ack_n;
         HOST_BUS_REQ_O <= next_host_req;
         pci_on <= 1'b1;
      end
   end

   assign GNT_OE_O = pci_on;
   assign BRIDGE_HOLD_ACK_OE_O = pci_on;

   // ----------------------------------------------------------------
   // processor lock
   // ----------------------------------------------------------------
   logic next_lock_oe;

   // lock only starts when the host owns an idle bus; arbitration is
   // not frozen, so other masters still reach their targets
   always_comb
   begin
      next_lock_oe = BUS_LOCK_OE_O;
      if (!CPU_LOCK_I)
         next_lock_oe = 1'b0;
      else if (bus_idle && (&gnt_n))
         next_lock_oe = 1'b1;
   end

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         BUS_LOCK_OE_O <= 1'b0;
         BUS_LOCK_N_O <= 1'b1;
      end
      else
      begin
         BUS_LOCK_OE_O <= next_lock_oe;
         BUS_LOCK_N_O <= ~next_lock_oe;
      end
   end

   // ----------------------------------------------------------------
   // target response
   // ----------------------------------------------------------------
   phac_tgt_t tstate;
   phac_tgt_t next_tstate;
   logic is_read;
   logic next_is_read;
   logic next_devsel_n;
   logic next_trdy_n;
   logic next_stop_n;
   logic next_tgt_oe;
   logic next_ad_oe;
   logic [AD_W-1:0] next_ad;

   always_comb
   begin
      next_tstate = tstate;
      next_is_read = is_read;
      next_devsel_n = 1'b1;
      next_trdy_n = 1'b1;
      next_stop_n = 1'b1;
      next_tgt_oe = 1'b1;
      next_ad_oe = 1'b0;
      next_ad = AD_O;
      case (tstate)
         T_IDLE:
         begin
            next_tgt_oe = 1'b0;
            if (addr_hit)
            begin
               next_tstate = T_DECODE;
               next_is_read = ~CBE_N_I[0];
            end
         end
         T_DECODE:
         begin
            next_devsel_n = 1'b0;
            next_ad_oe = is_read;
            next_ad = RD_DATA_I;
            if (TGT_RETRY_I)
            begin
               next_stop_n = 1'b0;
               next_tstate = T_STOP;
            end
            else
               next_tstate = T_DATA;
         end
         T_DATA:
         begin
            next_devsel_n = 1'b0;
            if (!TRDY_N_O && !IRDY_N_I && FRAME_N_I)
            begin
               next_devsel_n = 1'b1;
               next_tstate = T_TURN;
            end
            else if (TGT_RETRY_I)
            begin
               next_stop_n = 1'b0;
               next_tstate = T_STOP;
            end
            else
            begin
               next_trdy_n = ~TGT_READY_I;
               next_ad_oe = is_read;
               next_ad = RD_DATA_I;
            end
         end
         T_STOP:
         begin
            // stop stands until the master drops frame
            if (FRAME_N_I)
               next_tstate = T_TURN;
            else
            begin
               next_devsel_n = 1'b0;
               next_stop_n = 1'b0;
            end
         end
         T_TURN:
            // two cycles driven high before floating the shared lines
            next_tstate = T_IDLE;
         default:
            next_tstate = T_IDLE;
      endcase
   end

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         tstate <= T_IDLE;
         is_read <= 1'b0;
         frame_q <= 1'b1;
         DEVSEL_N_O <= 1'b1;
         TRDY_N_O <= 1'b1;
         STOP_N_O <= 1'b1;
         TGT_OE_O <= 1'b0;
         AD_OE_O <= 1'b0;
         AD_O <= '0;
      end
      else
      begin
         tstate <= next_tstate;
         is_read <= next_is_read;
         frame_q <= FRAME_N_I;
         DEVSEL_N_O <= next_devsel_n;
         TRDY_N_O <= next_trdy_n;
         STOP_N_O <= next_stop_n;
         TGT_OE_O <= next_tgt_oe;
         AD_OE_O <= next_ad_oe;
         AD_O <= next_ad;
      end
   end

   // ----------------------------------------------------------------
   // parity, system error and clock run
   // ----------------------------------------------------------------
   logic chk_pend;
   logic exp_par;
   logic par_bad;
   logic cr_need;

   assign par_bad = chk_pend & (PAR_I != exp_par);
   assign cr_need = CLK_NEEDED_I | (req_m != '0) | ~bus_idle;

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         chk_pend <= 1'b0;
         exp_par <= 1'b0;
         PAR_O <= 1'b0;
         PAR_OE_O <= 1'b0;
         SERR_N_O <= 1'b1;
         SERR_OE_O <= 1'b0;
         CLKRUN_N_O <= 1'b1;
         CLKRUN_OE_O <= 1'b0;
      end
      else
      begin
         chk_pend <= addr_phase;
         exp_par <= phac_parity(AD_I, CBE_N_I);
         PAR_O <= phac_parity(AD_O, CBE_N_I);
         PAR_OE_O <= AD_OE_O;
         // open drain: only ever pulled low, never driven high
         SERR_N_O <= 1'b0;
         SERR_OE_O <= par_bad | ERR_EVENT_I;
         CLKRUN_N_O <= 1'b0;
         // one-cycle pull, then re-sample; stays released while idle
         CLKRUN_OE_O <= ~CLKRUN_OE_O & cr_high & cr_need;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RST_N_I);

   chk_stop_held: assert property (
      !STOP_N_O && !FRAME_N_I |=> !STOP_N_O)
      else $error("stop released before frame ended");
   chk_lock_cpu: assert property (
      $rose(BUS_LOCK_OE_O) |-> $past(CPU_LOCK_I) && $past(bus_idle))
      else $error("lock driven without processor lock");
   chk_lock_flow: assert property (
      BUS_LOCK_OE_O && bus_idle && (req_m != '0) && (&gnt_n) &&
      (hstate == H_IDLE) |=> (~GNT_N_O) != '0)
      else $error("lock blocked other masters");
   chk_grant_req: assert property (
      ((~GNT_N_O) & $past(GNT_N_O) & ~$past(req_m)) == '0)
      else $error("grant without request");
   chk_hold_order: assert property (
      $fell(BRIDGE_HOLD_ACK_N_O) |-> $past(HOST_BUS_GNT_I) &&
      $past(HOST_BUS_REQ_O, 2) && $past(hstate == H_HOST))
      else $error("hold acked before drain and host bus");
   chk_ack_drop: assert property (
      !BRIDGE_HOLD_ACK_N_O && !hold_req |=> BRIDGE_HOLD_ACK_N_O)
      else $error("ack kept after hold request dropped");
   chk_passive_rel: assert property (
      hstate == H_PASSIVE |-> BRIDGE_HOLD_ACK_N_O && HOST_BUS_REQ_O)
      else $error("passive release kept ack");
   chk_par_gen: assert property (
      PAR_OE_O |-> PAR_O == ^{$past(AD_O), $past(CBE_N_I)})
      else $error("wrong generated parity");
   chk_serr_par: assert property (
      par_bad |=> SERR_OE_O && !SERR_N_O)
      else $error("address parity error not reported");
   chk_clkrun_req: assert property (
      CLKRUN_OE_O |-> $past(cr_high) && $past(cr_need) ##1 !CLKRUN_OE_O)
      else $error("clock run pulled without need");
   chk_clkrun_rst: assert property (
      $rose(RST_N_I) |-> !CLKRUN_OE_O)
      else $error("clock run driven at reset release");
   chk_rst_float: assert property (disable iff (1'b0)
      !RST_N_I |-> !(GNT_OE_O || TGT_OE_O || AD_OE_O || CLKRUN_OE_O))
      else $error("output driven in reset");
   chk_devsel_med: assert property (
      addr_hit |-> ##2 !DEVSEL_N_O && TGT_OE_O)
      else $error("device select not at medium timing");
   chk_one_grant: assert property (
      $onehot0({~GNT_N_O, ~BRIDGE_HOLD_ACK_N_O}))
      else $error("more than one grant");

   cov_hold_ack: cover property ($fell(BRIDGE_HOLD_ACK_N_O));
   cov_passive: cover property (hstate == H_PASSIVE);
   cov_stop: cover property (!STOP_N_O ##1 FRAME_N_I);
   cov_read: cover property (AD_OE_O && !TRDY_N_O);
endmodule
`default_nettype wire

// >>> hw/phac_pkg.sv
package phac_pkg;
   localparam int NUM_MASTERS = 5;
   localparam int ARB_W = NUM_MASTERS + 1;
   localparam int HOLD_SLOT = NUM_MASTERS;
   localparam int SYNC_W = NUM_MASTERS + 2;
   localparam int AD_W = 32;
   localparam int CBE_W = 4;
   // memory behind the bridge spans address zero up to this bound
   localparam logic [AD_W-1:0] DRAM_TOP = 32'h1000_0000;
   localparam logic [CBE_W-1:0] CMD_MEM_RD = 4'h6;
   localparam logic [CBE_W-1:0] CMD_MEM_WR = 4'h7;
   localparam logic [CBE_W-1:0] CMD_MEM_RD_MULT = 4'hc;
   localparam logic [CBE_W-1:0] CMD_MEM_RD_LINE = 4'he;
   localparam logic [CBE_W-1:0] CMD_MEM_WR_INV = 4'hf;
   localparam logic [SYNC_W-1:0] SYNC_RST = 7'h7f;
   localparam logic [2:0] ARB_PTR_RST = 3'h5;

   typedef enum logic [4:0]
   {
      H_IDLE = 5'h01,
      H_DRAIN = 5'h02,
      H_HOST = 5'h04,
      H_ACK = 5'h08,
      H_PASSIVE = 5'h10
   } phac_hold_t;

   typedef enum logic [4:0]
   {
      T_IDLE = 5'h01,
      T_DECODE = 5'h02,
      T_DATA = 5'h04,
      T_STOP = 5'h08,
      T_TURN = 5'h10
   } phac_tgt_t;

   function automatic logic phac_parity(input logic [AD_W-1:0] ad,
                                        input logic [CBE_W-1:0] cbe);
      phac_parity = ^{ad, cbe};
   endfunction
endpackage

// >>> hw/phac_sync.sv
`timescale 1ns/100ps
`default_nettype none
module phac_sync
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [phac_pkg::SYNC_W-1:0] d_i,
   output logic [phac_pkg::SYNC_W-1:0] q_o
);
   import phac_pkg::*;
   logic [SYNC_W-1:0] stage1;

   // first stage feeds only the second stage
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         stage1 <= SYNC_RST;
         q_o <= SYNC_RST;
      end
      else
      begin
         stage1 <= d_i;
         q_o <= stage1;
      end
   end
endmodule
`default_nettype wire

// >>> hw/phac_arb.sv
`timescale 1ns/100ps
`default_nettype none
module phac_arb
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [phac_pkg::ARB_W-1:0] req_i,
   input wire logic bus_idle_i,
   output logic [phac_pkg::ARB_W-1:0] gnt_n_o
);
   import phac_pkg::*;
   logic [2:0] ptr;
   logic [2:0] next_ptr;
   logic [ARB_W-1:0] next_gnt_n;
   logic hit;
   int idx;

   // rotate from the last winner; no preemption, owner keeps the grant
   // while it still requests, so a long burst delays the others
   always_comb
   begin
      next_gnt_n = gnt_n_o;
      next_ptr = ptr;
      hit = 1'b0;
      idx = 0;
      if ((~gnt_n_o & req_i) == '0)
      begin
         next_gnt_n = '1;
         if (bus_idle_i)
         begin
            for (int k = 1; k <= ARB_W; k++)
            begin
               idx = (int'(ptr) + k) % ARB_W;
               if (!hit && req_i[idx])
               begin
                  hit = 1'b1;
                  next_gnt_n[idx] = 1'b0;
                  next_ptr = 3'(idx);
               end
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         gnt_n_o <= '1;
         ptr <= ARB_PTR_RST;
      end
      else
      begin
         gnt_n_o <= next_gnt_n;
         ptr <= next_ptr;
      end
   end
endmodule
`default_nettype wire

// >>> bench/phac_partner.sv
`timescale 1ns/100ps
`default_nettype none
// --------------------------------------------------
// bus masters, expansion bridge and clock-run pull-up
// --------------------------------------------------
module phac_partner
(
   input wire logic clk_i,
   input wire logic [phac_pkg::NUM_MASTERS-1:0] want_i,
   input wire logic hold_want_i,
   input wire logic clkrun_drv_n_i,
   input wire logic clkrun_oe_i,
   output logic [phac_pkg::NUM_MASTERS-1:0] req_n_o,
   output logic hold_req_n_o,
   output logic clkrun_n_o
);
   import phac_pkg::*;

   // requests move on the edge itself, so the late drive of the wish
   // lines by the bench never races the model
   always @(posedge clk_i)
   begin
      req_n_o <= ~want_i;
      // bridge keeps asking through a passive release
      hold_req_n_o <= ~hold_want_i;
   end

   // open drain: low only while pulled, the pull-up wins otherwise
   assign clkrun_n_o = !(clkrun_oe_i && !clkrun_drv_n_i);
endmodule
`default_nettype wire

// >>> bench/phac_pci_ctrl_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
   begin \
      checked++; \
      if ((g) !== (e)) \
      begin \
         err_count++; \
         $display("Error %s expected %h seen %h", nm, e, g); \
      end \
   end
module phac_pci_ctrl_bench;
   import phac_pkg::*;
   // --------------------------------------------------
   // signals
   // --------------------------------------------------
   logic clk, rst_n, hold_n, hack_n, hack_oe, wr_empty, post_empty, hreq;
   logic hgnt, lock, lock_n, lock_oe, frame_n, irdy_n, par, ad_oe, par_o;
   logic par_oe, devsel_n, trdy_n, stop_n, tgt_oe, err_ev, serr_n, serr_oe;
   logic clk_need, clkrun_n, clkrun_o, clkrun_oe, tready, retry, gnt_oe;
   logic hold_want;
   logic [4:0] req_n, gnt_n, want;
   logic [31:0] ad, rd_data, ad_o, seed, prev_ad;
   logic [3:0] cbe, prev_cbe;
   logic [3:0] mc [5] = '{CMD_MEM_RD, CMD_MEM_WR, CMD_MEM_RD_MULT,
                          CMD_MEM_RD_LINE, CMD_MEM_WR_INV};
   int err_count, checked, serr_cnt, n, w, last, s;

   phac_pci_ctrl phac_pci_ctrl_inst (.CLK_I(clk), .RST_N_I(rst_n),
      .REQ_N_I(req_n), .GNT_N_O(gnt_n), .GNT_OE_O(gnt_oe),
      .BRIDGE_HOLD_REQUEST_N_I(hold_n), .BRIDGE_HOLD_ACK_N_O(hack_n),
      .BRIDGE_HOLD_ACK_OE_O(hack_oe), .WR_BUF_EMPTY_I(wr_empty),
      .POST_BUF_EMPTY_I(post_empty), .HOST_BUS_REQ_O(hreq),
      .HOST_BUS_GNT_I(hgnt), .CPU_LOCK_I(lock), .BUS_LOCK_N_O(lock_n),
      .BUS_LOCK_OE_O(lock_oe), .FRAME_N_I(frame_n), .IRDY_N_I(irdy_n),
      .AD_I(ad), .CBE_N_I(cbe), .PAR_I(par), .RD_DATA_I(rd_data),
      .TGT_READY_I(tready), .TGT_RETRY_I(retry), .AD_O(ad_o),
      .AD_OE_O(ad_oe), .PAR_O(par_o), .PAR_OE_O(par_oe),
      .DEVSEL_N_O(devsel_n), .TRDY_N_O(trdy_n), .STOP_N_O(stop_n),
      .TGT_OE_O(tgt_oe), .ERR_EVENT_I(err_ev), .SERR_N_O(serr_n),
      .SERR_OE_O(serr_oe), .CLK_NEEDED_I(clk_need), .CLKRUN_N_I(clkrun_n),
      .CLKRUN_N_O(clkrun_o), .CLKRUN_OE_O(clkrun_oe));

   phac_partner phac_partner_inst (.clk_i(clk), .want_i(want),
      .hold_want_i(hold_want), .clkrun_drv_n_i(clkrun_o),
      .clkrun_oe_i(clkrun_oe), .req_n_o(req_n), .hold_req_n_o(hold_n),
      .clkrun_n_o(clkrun_n));

   // --------------------------------------------------
   // helpers
   // --------------------------------------------------
   always #25 clk = ~clk;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
   endfunction

   // rotating priority: first requester after the last winner
   function automatic int exp_win(input logic [5:0] m, input int l);
      exp_win = -1;
      for (int i = 6; i >= 1; i--)
      begin
         if (m[(l + i) % 6] === 1'b1)
            exp_win = (l + i) % 6;
      end
   endfunction

   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #2;
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // pulses are counted at the edge after they rise
   always @(posedge clk)
   begin
      if (serr_oe === 1'b1)
         serr_cnt++;
   end

   // read parity trails the data by one cycle
   always @(negedge clk)
   begin
      if (par_oe === 1'b1)
         `CHK("read parity", ^{prev_ad, prev_cbe}, par_o);
      prev_ad = ad_o;
      prev_cbe = cbe;
   end

   // single data phase as master; the address parity comes a cycle late
   task automatic tgt(input logic [31:0] a, input logic [3:0] c,
                      input logic bad, input logic rty, input logic claim);
      int s0;
      s0 = serr_cnt;
      frame_n = 1'b0;
      ad = a;
      cbe = c;
      step(1);
      frame_n = 1'b1;
      irdy_n = 1'b0;
      cbe = 4'h0;
      par = ^{a, c} ^ bad;
      ad = rnd();
      rd_data = rnd();
      retry = rty;
      `CHK("no early claim", 1'b1, devsel_n);
      step(1);
      // medium decode: driven now, sampled by the master at the next edge
      `CHK("claim", !claim, devsel_n);
      `CHK("target enable", claim, tgt_oe);
      `CHK("read enable", claim & ~c[0], ad_oe);
      for (n = 0; n < 10 && claim && (trdy_n && stop_n); n++) step(1);
      if (claim)
         `CHK("stop on retry", !rty, stop_n);
      if (claim)
         `CHK("target ready", rty, trdy_n);
      if (claim && !c[0])
         `CHK("read data", rd_data, ad_o);
      // master holds irdy through the edge that samples trdy or stop
      step(1);
      irdy_n = 1'b1;
      retry = 1'b0;
      step(4);
      `CHK("target released", 1'b0, tgt_oe);
      `CHK("address parity", int'(bad), serr_cnt - s0);
   endtask

   // --------------------------------------------------
   // scenarios
   // --------------------------------------------------
   initial
   begin
      {clk, want, hold_want, hgnt, lock, par, retry} = '0;
      rst_n = 1'b1;
      {err_ev, clk_need, ad, cbe, rd_data} = '0;
      {wr_empty, post_empty, frame_n, irdy_n, tready} = '1;
      err_count = 0;
      checked = 0;
      serr_cnt = 0;
      seed = 32'h0000_13a2;
      // reset falls off time zero so the asynchronous branch sees an edge
      #1;
      rst_n = 1'b0;
      step(5);
      `CHK("float in reset", 8'h00, {gnt_oe, hack_oe, lock_oe, ad_oe,
           par_oe, tgt_oe, serr_oe, clkrun_oe});
      `CHK("grants idle in reset", 5'h1f, gnt_n);
      rst_n = 1'b1;
      step(1);
      `CHK("clock-run released", 1'b0, clkrun_oe);
      // all five asking first walks the rotation, then random masks
      last = HOLD_SLOT;
      for (int r = 0; r < 24; r++)
      begin
         want = (r < 5) ? 5'h1f : 5'(rnd());
         if (want === 5'h00)
            want = 5'h10;
         for (n = 0; n < 20 && gnt_n === 5'h1f; n++) step(1);
         w = exp_win({1'b0, want}, last);
         `CHK("grant", ~(5'h01 << w), gnt_n);
         last = w;
         want = 5'h00;
         for (n = 0; n < 20 && gnt_n !== 5'h1f; n++) step(1);
         `CHK("grant released", 5'h1f, gnt_n);
      end
      // bridge hold waits for both buffers and the host bus
      wr_empty = 1'b0;
      post_empty = 1'b0;
      hold_want = 1'b1;
      step(8);
      `CHK("drain first", 2'b01, {hreq, hack_n});
      wr_empty = 1'b1;
      step(8);
      `CHK("posting drain", 2'b01, {hreq, hack_n});
      post_empty = 1'b1;
      for (n = 0; n < 10 && hreq !== 1'b1; n++) step(1);
      step(6);
      `CHK("host bus first", 2'b11, {hreq, hack_n});
      hgnt = 1'b1;
      for (n = 0; n < 10 && hack_n !== 1'b0; n++) step(1);
      `CHK("hold ack", 6'h1f, {hack_n, gnt_n});
      want = 5'h04;
      for (n = 0; n < 10 && hack_n !== 1'b1; n++) step(1);
      `CHK("passive release", 2'b10, {hack_n, hold_n});
      for (n = 0; n < 10 && gnt_n === 5'h1f; n++) step(1);
      `CHK("master after release", 6'h3b, {hack_n, gnt_n});
      want = 5'h00;
      hold_want = 1'b0;
      step(8);
      hgnt = 1'b0;
      step(4);
      // every memory command claimed, one retried, then refusals
      for (int i = 0; i < 5; i++)
         tgt(rnd() & 32'h0fff_fffc, mc[i], 1'b0, i == 2, 1'b1);
      tgt(DRAM_TOP - 32'h4, CMD_MEM_RD, 1'b0, 1'b0, 1'b1);
      tgt(DRAM_TOP, CMD_MEM_RD, 1'b1, 1'b0, 1'b0);
      tgt(32'h0000_0010, 4'h2, 1'b0, 1'b0, 1'b0);
      // processor lock leaves arbitration running
      lock = 1'b1;
      step(4);
      `CHK("lock driven", 2'b10, {lock_oe, lock_n});
      want = 5'h08;
      for (n = 0; n < 20 && gnt_n === 5'h1f; n++) step(1);
      `CHK("grant during lock", 5'h17, gnt_n);
      want = 5'h00;
      lock = 1'b0;
      step(2);
      `CHK("lock released", 1'b0, lock_oe);
      step(8);
      err_ev = 1'b1;
      step(1);
      err_ev = 1'b0;
      s = serr_cnt;
      step(3);
      `CHK("system error", 1, serr_cnt - s);
      `CHK("system error level", 1'b0, serr_n);
      clk_need = 1'b1;
      for (n = 0; n < 10 && clkrun_oe !== 1'b1; n++) step(1);
      `CHK("clock-run pull", 3'b100, {clkrun_oe, clkrun_o, clkrun_n});
      step(1);
      `CHK("clock-run let go", 2'b01, {clkrun_oe, clkrun_n});
      clk_need = 1'b0;
      // reset in mid-cycle with a grant out must act before any edge
      want = 5'h01;
      for (n = 0; n < 20 && gnt_n === 5'h1f; n++) step(1);
      #10;
      rst_n = 1'b0;
      #5;
      `CHK("async reset", 6'h1f, {gnt_oe, gnt_n});
      want = 5'h00;
      step(3);
      rst_n = 1'b1;
      step(1);
      `CHK("clock-run after reset", 1'b0, clkrun_oe);
      end_of_test();
   end

   // a hang is cut short well past the expected run
   initial
   begin
      repeat (5000) @(posedge clk);
      err_count++;
      end_of_test();
   end
endmodule
`undef CHK
`default_nettype wire
